// ---- logic/vbcs_defs.svh ----
// Constants of the video buffer channel configuration link.
// Assumes it is included by bare name wherever the values are needed.
`ifndef VBCS_DEFS_SVH
`define VBCS_DEFS_SVH
// Fixed upper five slave address bits.
`define VBCS_DEV_ID      5'h0B
// Channel register sub-addresses.
`define VBCS_SUB_CH1     8'h01
`define VBCS_SUB_CH2     8'h02
`define VBCS_SUB_CH3     8'h03
// Channel register field positions.
`define VBCS_CLAMP_MSB   7
`define VBCS_CLAMP_LSB   6
`define VBCS_MUX_BIT     5
`define VBCS_LPF_MSB     4
`define VBCS_LPF_LSB     3
`define VBCS_BIAS_MSB    2
`define VBCS_BIAS_LSB    0
// Byte clocked out once after reset to flush the slave.
`define VBCS_FLUSH_BYTE  8'h00
// Timing: clock period, serial clock period, quarter period in cycles.
`define VBCS_MCLK_NS     25
`define VBCS_SCL_NS      10000
`define VBCS_QUARTER     (`VBCS_SCL_NS / (4 * `VBCS_MCLK_NS))
`endif

// ---- logic/vbcs_pkg.sv ----
// Types shared by both ends of the channel configuration link.
// Assumes nothing beyond a SystemVerilog compiler.
package vbcs_pkg;
   typedef enum logic [1:0] {
      VBCS_CLAMP_500K = 2'h0,
      VBCS_CLAMP_2M5  = 2'h1,
      VBCS_CLAMP_5M   = 2'h2
   } vbcs_clamp_e;
   typedef enum logic [2:0] {
      VBCS_BIAS_OFF   = 3'h0,
      VBCS_BIAS_MUTE  = 3'h1,
      VBCS_BIAS_DC    = 3'h2,
      VBCS_BIAS_DCOFS = 3'h3,
      VBCS_BIAS_AC    = 3'h4,
      VBCS_BIAS_TCLO  = 3'h5,
      VBCS_BIAS_TCMID = 3'h6,
      VBCS_BIAS_TCHI  = 3'h7
   } vbcs_bias_e;
   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_ADDR   = 4'h1,
      S_ACK_A  = 4'h2,
      S_SUB    = 4'h3,
      S_ACK_S  = 4'h4,
      S_DATA   = 4'h5,
      S_ACK_D  = 4'h6,
      S_TX     = 4'h7,
      S_RACK   = 4'h8,
      S_IGNORE = 4'h9
   } vbcs_sstate_e;
   typedef enum logic [1:0] {
      M_IDLE  = 2'h0,
      M_START = 2'h1,
      M_BYTE  = 2'h2,
      M_STOP  = 2'h3
   } vbcs_mstate_e;
   typedef enum logic [1:0] {
      K_ADDR = 2'h0,
      K_SUB  = 2'h1,
      K_DATA = 2'h2,
      K_RX   = 2'h3
   } vbcs_kind_e;
endpackage : vbcs_pkg

// ---- logic/vbcs_if.sv ----
// Open-drain two-wire link between the master and the slave end.
// Assumes pull-ups: a line is low only while some enable is low.
`timescale 1ns/1ps
interface vbcs_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;

   assign scl = m_scl_oe_n | m_scl_o;
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

   modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n,
                   input  scl, sda);
   modport slave  (output s_sda_o, s_sda_oe_n,
                   input  scl, sda);
endinterface : vbcs_if

// ---- logic/vbcs_sync.sv ----
// Two-flop synchroniser with edge detection on the settled level.
// Assumes inputs idle high; edges are seen in the same cycle the level settles.
`timescale 1ns/1ps
module vbcs_sync #(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // Asynchronous inputs
   input  wire logic [WIDTH-1:0] async_in,
   // Settled level and one-cycle edge pulses
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] held;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta  <= '1;
         level <= '1;
         held  <= '1;
      end
      else
      begin
         meta  <= async_in;
         level <= meta;
         held  <= level;
      end
   end

   assign rise = level & ~held;
   assign fall = ~level & held;
endmodule : vbcs_sync

// ---- logic/vbcs_slave.sv ----
// Slave end: three channel configuration registers behind the link.
// Assumes mclk is many times the serial clock and that the master
// changes the data line only while the serial clock is low.
// Summary of operation
// [R1] One data byte per transaction only.
// [R2] Sub-address 01, 02, 03 selects channel.
// [R3] Bits 7:6 pick clamp filter rate.
// [R4] Clamp field ignored outside tip-clamp modes.
// [R5] Bit 5 selects input A or B.
// [R6] Bits 4:3 pick lowpass corner or bypass.
// [R7] Bits 2:0 pick bias, mute or disable.
// [R8] Write: address, sub-address, data, each acknowledged.
// [R9] Acknowledge held low until next clock fall.
// [R10] Master writes each channel separately.
// [R11] Read phase one sets sub-address, then stop.
// [R12] Read phase two: address, byte, nack, stop.
// [R13] Read returns register picked by last sub-address.
// [R14] Master repeats both phases per channel.
// [R15] Address bits 2:1 follow select pins.
// [R16] Upper five address bits must be 01011.
// [R17] Registers are random until first written.
// [R18] Master clocks a flush byte after power-up.
// [R19] Update only after acknowledged valid data byte.
`timescale 1ns/1ps
`include "vbcs_defs.svh"
module vbcs_slave
   import vbcs_pkg::*;
(
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // Serial link
   vbcs_if.slave                 bus,
   // Address select pins
   input  wire logic             addr_select_hi,
   input  wire logic             addr_select_lo,
   // Channel controls, index 0 is channel one
   output logic      [2:0]       tip_clamp_en,
   output logic      [2:0][1:0]  tip_clamp,
   output logic      [2:0]       input_b_sel,
   output logic      [2:0][1:0]  lowpass_corner,
   output logic      [2:0][2:0]  bias_mode,
   output logic      [2:0]       chan_on,
   output logic      [2:0]       chan_mute
);
   logic [1:0]   pin_lvl;
   logic [1:0]   pin_rise;
   logic [1:0]   pin_fall;
   logic [1:0]   sel_lvl;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_seen;
   logic         stop_seen;
   logic         rx_state;
   logic         full;
   logic         addr_ok;
   logic         sub_ok;
   logic [1:0]   sub_idx;
   logic         cfg_write;
   logic [7:0]   rd_byte;
   logic [7:0]   chan_cfg [3];
   logic [3:0]   cnt;
   logic [7:0]   shift;
   logic [7:0]   sub_ptr;
   logic [7:0]   tx_sh;
   vbcs_sstate_e state;
   vbcs_sstate_e next_state;

   vbcs_sync #(.WIDTH(2)) u_bus_sync
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in ({bus.scl, bus.sda}),
      .level    (pin_lvl),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   vbcs_sync #(.WIDTH(2)) u_sel_sync
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in ({addr_select_hi, addr_select_lo}),
      .level    (sel_lvl),
      .rise     (),
      .fall     ()
   );

   assign scl_rise   = pin_rise[1];
   assign scl_fall   = pin_fall[1];
   assign start_seen = pin_lvl[1] & pin_fall[0];
   assign stop_seen  = pin_lvl[1] & pin_rise[0];
   assign rx_state   = (state == S_ADDR) | (state == S_SUB) |
                       (state == S_DATA);
   assign full       = (cnt == 4'h8);
   assign addr_ok    = (shift[7:3] == `VBCS_DEV_ID) &  // [R16]
                       (shift[2:1] == sel_lvl);        // [R15]
   assign sub_ok     = (sub_ptr == `VBCS_SUB_CH1) |    // [R2]
                       (sub_ptr == `VBCS_SUB_CH2) |
                       (sub_ptr == `VBCS_SUB_CH3);
   assign sub_idx    = sub_ptr[1:0] - 2'h1;
   assign rd_byte    = sub_ok ? chan_cfg[sub_idx] : 8'h00; // [R13]
   assign cfg_write  = scl_fall & (state == S_ACK_D) & sub_ok &
                       ~start_seen & ~stop_seen;        // [R19]

   // Transaction sequencing driven by serial clock edges.
   always_comb
   begin
      next_state = state;
      if (stop_seen)
      begin
         next_state = S_IDLE;                 // [R11]
      end
      else if (start_seen)
      begin
         next_state = S_ADDR;
      end
      else if (scl_fall)
      begin
         unique case (state)
            S_IDLE, S_IGNORE:
            begin
               next_state = state;
            end
            S_ADDR:
            begin
               if (full)
               begin
                  next_state = addr_ok ? S_ACK_A : S_IGNORE; // [R16]
               end
            end
            S_SUB:
            begin
               if (full)
               begin
                  next_state = S_ACK_S;       // [R8]
               end
            end
            S_DATA:
            begin
               if (full)
               begin
                  next_state = S_ACK_D;       // [R8]
               end
            end
            S_ACK_A:
            begin
               next_state = shift[0] ? S_TX : S_SUB; // [R12]
            end
            S_ACK_S:
            begin
               next_state = S_DATA;
            end
            S_ACK_D:
            begin
               next_state = S_IGNORE;         // [R1]
            end
            S_TX:
            begin
               if (cnt == 4'h7)
               begin
                  next_state = S_RACK;
               end
            end
            S_RACK:
            begin
               next_state = S_IGNORE;         // [R12]
            end
            default:
            begin
               next_state = S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= S_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Bit counter: received bits in receive states, falls in transmit.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 4'h0;
      end
      else if (next_state != state || start_seen)
      begin
         cnt <= 4'h0;
      end
      else if (rx_state && scl_rise)
      begin
         cnt <= cnt + 4'h1;
      end
      else if (state == S_TX && scl_fall)
      begin
         cnt <= cnt + 4'h1;
      end
   end

   // Receive shifter, MSB first, sampled on the rising clock.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift <= 8'h00;
      end
      else if (rx_state && scl_rise && !full)
      begin
         shift <= {shift[6:0], pin_lvl[0]};    // [R8]
      end
   end

   // Sub-address pointer, kept across transactions for later reads.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sub_ptr <= 8'h00;
      end
      else if (scl_fall && state == S_SUB && next_state == S_ACK_S)
      begin
         sub_ptr <= shift;                     // [R11]
      end
   end

   // Transmit shifter for the single read byte.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh <= 8'h00;
      end
      else if (scl_fall && next_state == S_TX)
      begin
         tx_sh <= (state == S_TX) ? {tx_sh[6:0], 1'b0} : rd_byte;
      end
   end

   // Data line drive: low enable pulls the wire low.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus.s_sda_oe_n <= 1'b1;
         bus.s_sda_o    <= 1'b0;
      end
      else if (start_seen || stop_seen)
      begin
         bus.s_sda_oe_n <= 1'b1;
      end
      else if (scl_fall)
      begin
         if (next_state == S_ACK_A || next_state == S_ACK_S ||
             next_state == S_ACK_D)
         begin
            bus.s_sda_oe_n <= 1'b0;             // [R9]
         end
         else if (next_state == S_TX)
         begin
            bus.s_sda_oe_n <= (state == S_TX) ? tx_sh[6] : rd_byte[7];
         end
         else
         begin
            bus.s_sda_oe_n <= 1'b1;             // [R9]
         end
      end
   end

   // Channel registers have no reset and power up random.
   always_ff @(posedge mclk)
   begin
      if (cfg_write)
      begin
         chan_cfg[sub_idx] <= shift;           // [R17] [R19]
      end
   end

   // Decoded channel controls.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tip_clamp_en   <= '0;
         tip_clamp      <= '0;
         input_b_sel    <= '0;
         lowpass_corner <= '0;
         bias_mode      <= '0;
         chan_on        <= '0;
         chan_mute      <= '0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            tip_clamp_en[i] <= (chan_cfg[i][`VBCS_BIAS_MSB:`VBCS_BIAS_LSB]
                                >= VBCS_BIAS_TCLO);       // [R4]
            if (chan_cfg[i][`VBCS_BIAS_MSB:`VBCS_BIAS_LSB] < VBCS_BIAS_TCLO)
            begin
               tip_clamp[i] <= VBCS_CLAMP_500K;          // [R4]
            end
            else if (chan_cfg[i][`VBCS_CLAMP_MSB])
            begin
               tip_clamp[i] <= VBCS_CLAMP_5M;            // [R3]
            end
            else
            begin
               tip_clamp[i] <= {1'b0, chan_cfg[i][`VBCS_CLAMP_LSB]}; // [R3]
            end
            input_b_sel[i]    <= chan_cfg[i][`VBCS_MUX_BIT];        // [R5]
            lowpass_corner[i] <=
               chan_cfg[i][`VBCS_LPF_MSB:`VBCS_LPF_LSB];            // [R6]
            bias_mode[i]      <=
               chan_cfg[i][`VBCS_BIAS_MSB:`VBCS_BIAS_LSB];          // [R7]
            chan_on[i]   <= (chan_cfg[i][`VBCS_BIAS_MSB:`VBCS_BIAS_LSB]
                             != VBCS_BIAS_OFF);                     // [R7]
            chan_mute[i] <= (chan_cfg[i][`VBCS_BIAS_MSB:`VBCS_BIAS_LSB]
                             == VBCS_BIAS_MUTE);                    // [R7]
         end
      end
   end
endmodule : vbcs_slave

// ---- logic/vbcs_master.sv ----
// Master end: turns single commands into complete link transactions.
// Assumes a slave without clock stretching; the serial clock is made
// here from mclk by a quarter-period divider.
`timescale 1ns/1ps
`include "vbcs_defs.svh"
module vbcs_master
   import vbcs_pkg::*;
#(
   parameter int QUARTER = `VBCS_QUARTER
)
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Serial link
   vbcs_if.master          bus,
   // Command
   input  wire logic       cmd_valid,
   input  wire logic       cmd_read,
   input  wire logic [1:0] cmd_sel,
   input  wire logic [7:0] cmd_sub,
   input  wire logic [7:0] cmd_data,
   output logic            cmd_ready,
   // Response
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_nack
);
   logic [15:0]  qcnt;
   logic         tick;
   logic [1:0]   phase;
   logic [3:0]   bitn;
   logic [7:0]   tx_sh;
   logic [7:0]   rx_sh;
   logic         sda_lvl;
   logic         flush;
   logic         ph2;
   logic         nack;
   logic         c_read;
   logic [1:0]   c_sel;
   logic [7:0]   c_sub;
   logic [7:0]   c_data;
   vbcs_kind_e   kind;
   vbcs_mstate_e mstate;

   vbcs_sync #(.WIDTH(1)) u_sda_sync
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in (bus.sda),
      .level    (sda_lvl),
      .rise     (),
      .fall     ()
   );

   assign tick = (qcnt == 16'(QUARTER - 1));

   // Quarter-period divider, running only during a transaction.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         qcnt <= 16'h0;
      end
      else if (mstate == M_IDLE || tick)
      begin
         qcnt <= 16'h0;
      end
      else
      begin
         qcnt <= qcnt + 16'h1;
      end
   end

   // Sequencer: start, bytes with acknowledge slots, stop.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mstate         <= M_START;             // [R18]
         flush          <= 1'b1;                // [R18]
         phase          <= 2'h0;
         bitn           <= 4'h0;
         kind           <= K_ADDR;
         tx_sh          <= 8'h00;
         rx_sh          <= 8'h00;
         ph2            <= 1'b0;
         nack           <= 1'b0;
         c_read         <= 1'b0;
         c_sel          <= 2'h0;
         c_sub          <= 8'h00;
         c_data         <= 8'h00;
         cmd_ready      <= 1'b0;
         rsp_valid      <= 1'b0;
         rsp_data       <= 8'h00;
         rsp_nack       <= 1'b0;
         bus.m_scl_o    <= 1'b0;
         bus.m_sda_o    <= 1'b0;
         bus.m_scl_oe_n <= 1'b1;
         bus.m_sda_oe_n <= 1'b1;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (mstate == M_IDLE)
         begin
            if (cmd_valid && cmd_ready)
            begin
               c_read    <= cmd_read;           // [R10] [R14]
               c_sel     <= cmd_sel;
               c_sub     <= cmd_sub;
               c_data    <= cmd_data;
               cmd_ready <= 1'b0;
               ph2       <= 1'b0;
               nack      <= 1'b0;
               phase     <= 2'h0;
               mstate    <= M_START;
            end
         end
         else if (tick)
         begin
            phase <= phase + 2'h1;
            unique case (mstate)
               M_START:
               begin
                  if (phase == 2'h1)
                  begin
                     bus.m_sda_oe_n <= 1'b0;
                  end
                  if (phase == 2'h2)
                  begin
                     bus.m_scl_oe_n <= 1'b0;
                  end
                  if (phase == 2'h3)
                  begin
                     mstate <= M_BYTE;
                     kind   <= K_ADDR;
                     bitn   <= 4'h0;
                     tx_sh  <= flush ? `VBCS_FLUSH_BYTE :
                               {`VBCS_DEV_ID, c_sel, ph2}; // [R15] [R12]
                  end
               end
               M_BYTE:
               begin
                  if (phase == 2'h0)
                  begin
                     bus.m_sda_oe_n <= (bitn == 4'h8 || kind == K_RX) ?
                                       1'b1 : tx_sh[7];     // [R12]
                     if (bitn != 4'h8)
                     begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                     end
                  end
                  if (phase == 2'h1)
                  begin
                     bus.m_scl_oe_n <= 1'b1;
                  end
                  if (phase == 2'h2)
                  begin
                     if (bitn == 4'h8)
                     begin
                        nack <= nack | (sda_lvl & ~flush & (kind == K_ADDR));
                     end
                     else
                     begin
                        rx_sh <= {rx_sh[6:0], sda_lvl};
                     end
                  end
                  if (phase == 2'h3)
                  begin
                     bus.m_scl_oe_n <= 1'b0;
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h8)
                     begin
                        bitn <= 4'h0;
                        if (kind == K_ADDR && !flush && !nack && ph2)
                        begin
                           kind <= K_RX;
                        end
                        else if (kind == K_ADDR && !flush && !nack)
                        begin
                           kind  <= K_SUB;              // [R8]
                           tx_sh <= c_sub;              // [R2]
                        end
                        else if (kind == K_SUB && !c_read)
                        begin
                           kind  <= K_DATA;
                           tx_sh <= c_data;
                        end
                        else
                        begin
                           mstate <= M_STOP;            // [R1] [R11]
                           if (kind == K_RX)
                           begin
                              rsp_data <= rx_sh;
                           end
                        end
                     end
                  end
               end
               M_STOP:
               begin
                  if (phase == 2'h0)
                  begin
                     bus.m_sda_oe_n <= 1'b0;
                  end
                  if (phase == 2'h1)
                  begin
                     bus.m_scl_oe_n <= 1'b1;
                  end
                  if (phase == 2'h2)
                  begin
                     bus.m_sda_oe_n <= 1'b1;
                  end
                  if (phase == 2'h3)
                  begin
                     if (c_read && !ph2 && !nack && !flush)
                     begin
                        ph2    <= 1'b1;                 // [R12] [R14]
                        mstate <= M_START;
                     end
                     else
                     begin
                        mstate    <= M_IDLE;
                        cmd_ready <= 1'b1;
                        flush     <= 1'b0;
                        rsp_valid <= ~flush;
                        rsp_nack  <= nack;
                     end
                  end
               end
               M_IDLE:
               begin
                  mstate <= M_IDLE;
               end
            endcase
         end
      end
   end
endmodule : vbcs_master

// ---- verification/vbcs_link_assertions.sv ----
// Checker of the two-wire link between the master and the slave end.
// Assumes a quarter period of four mclk cycles and pulled-up lines.
`timescale 1ns/1ps
module vbcs_link_assertions
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link drivers and resolved wires
   input wire logic m_scl_o,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_o,
   input wire logic m_sda_oe_n,
   input wire logic s_sda_o,
   input wire logic s_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_OPEN_DRAIN: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
      else $error("Link driver drives high");
   AST_SLV_TAKE: assert property ($fell(s_sda_oe_n) |-> !scl)
      else $error("Slave took data line while clock high");
   AST_SLV_FREE: assert property ($rose(s_sda_oe_n) |-> !scl)
      else $error("Slave released data line while clock high");
   AST_SLV_HOLD: assert property ($fell(s_sda_oe_n) |-> (!s_sda_oe_n)[*8])
      else $error("Slave drive shorter than a clock cycle");
   AST_ACK_HIGH: assert property (scl && !s_sda_oe_n |=> !s_sda_oe_n || !scl)
      else $error("Slave drive dropped in clock high phase");
   AST_MST_QUIET: assert property (!s_sda_oe_n && scl |-> m_sda_oe_n)
      else $error("Master drives data line in slave slot");
   AST_START_OWN: assert property ($fell(sda) && scl |-> s_sda_oe_n)
      else $error("Start condition made by the slave");
   AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*6])
      else $error("Clock high phase too short");
endmodule : vbcs_link_assertions

// ---- verification/tb_video_buffer_channel_config_slave.sv ----
// Bench joining master and slave ends, driving commands and pins.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
module tb_video_buffer_channel_config_slave;
   import vbcs_pkg::*;
   logic            mclk      = 1'b0;
   logic            rst_n     = 1'b0;
   logic            cmd_valid = 1'b0;
   logic            cmd_read  = 1'b0;
   logic [1:0]      cmd_sel   = 2'h0;
   logic [7:0]      cmd_sub   = 8'h00;
   logic [7:0]      cmd_data  = 8'h00;
   logic [1:0]      pins      = 2'h2;
   logic            cmd_ready;
   logic            rsp_valid;
   logic            rsp_nack;
   logic [7:0]      rsp_data;
   logic [2:0]      tce, ibs, con, cmu;
   logic [2:0][1:0] tcl, lpc;
   logic [2:0][2:0] bms;
   logic [7:0]      ref_v [4];
   logic [7:0]      d;
   int              fail_count  = 0;
   int              checks_done = 0;
   int              cycles      = 0;

   vbcs_if bus ();
   vbcs_master #(.QUARTER(4)) vbcs_master_i (.mclk, .rst_n, .bus,
      .cmd_valid, .cmd_read, .cmd_sel, .cmd_sub, .cmd_data, .cmd_ready,
      .rsp_valid, .rsp_data, .rsp_nack);
   vbcs_slave vbcs_slave_i (.mclk, .rst_n, .bus,
      .addr_select_hi(pins[1]), .addr_select_lo(pins[0]),
      .tip_clamp_en(tce), .tip_clamp(tcl), .input_b_sel(ibs),
      .lowpass_corner(lpc), .bias_mode(bms), .chan_on(con),
      .chan_mute(cmu));
   vbcs_link_assertions vbcs_link_assertions_i (.mclk, .rst_n,
      .m_scl_o(bus.m_scl_o), .m_scl_oe_n(bus.m_scl_oe_n),
      .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
      .s_sda_o(bus.s_sda_o), .s_sda_oe_n(bus.s_sda_oe_n),
      .scl(bus.scl), .sda(bus.sda));

   always #12.5 mclk = ~mclk;

   task automatic report_and_stop();
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("Error at %0t: run too long", $time);
         report_and_stop();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // One command: wait idle, hand it over, wait for the response.
   task automatic xfer(input logic rd, input logic [1:0] sel,
                       input logic [7:0] sub, input logic [7:0] dat);
      @(posedge mclk);
      while (cmd_ready !== 1'b1)
         @(posedge mclk);
      cmd_read  <= rd;
      cmd_sel   <= sel;
      cmd_sub   <= sub;
      cmd_data  <= dat;
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      while (rsp_valid !== 1'b1)
         @(posedge mclk);
   endtask : xfer

   task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
      xfer(1'b1, pins, sub, 8'h00);
      check({15'h0000, rsp_nack}, 16'h0000);
      check({8'h00, rsp_data}, {8'h00, exp});
   endtask : rd_chk

   task automatic rd_all();
      for (int c = 1; c < 4; c++)
         rd_chk(8'(c), ref_v[c]);
   endtask : rd_all

   task automatic dec_chk(input int i, input logic [7:0] v);
      logic       en;
      logic [1:0] cl;
      en = v[2] && (v[1:0] != 2'h0);
      cl = en ? (v[7] ? 2'h2 : {1'b0, v[6]}) : 2'h0;
      check({5'h00, tce[i], tcl[i], ibs[i], lpc[i], bms[i], con[i], cmu[i]},
            {5'h00, en, cl, v[5], v[4:3], v[2:0], v[2:0] != 3'h0,
             v[2:0] == 3'h1});
   endtask : dec_chk

   initial
   begin
      ref_v = '{8'h00, 8'hF5, 8'h2A, 8'h9B};
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      for (int c = 1; c < 4; c++)
      begin
         xfer(1'b0, pins, 8'(c), ref_v[c]);
         dec_chk(c - 1, ref_v[c]);
      end
      rd_all();
      for (int b = 0; b < 8; b++)
      begin
         d = {b[1:0], b[0], b[1:0], b[2:0]};
         xfer(1'b0, pins, 8'h02, d);
         dec_chk(1, d);
      end
      ref_v[2] = d;
      xfer(1'b0, ~pins, 8'h01, 8'h00);
      check({15'h0000, rsp_nack}, 16'h0001);
      xfer(1'b0, pins, 8'h81, 8'h00);
      rd_chk(8'h81, 8'h00);
      rd_all();
      pins <= 2'h1;
      repeat (8) @(posedge mclk);
      ref_v[3] = 8'h5C;
      xfer(1'b0, pins, 8'h03, ref_v[3]);
      dec_chk(2, ref_v[3]);
      rd_all();
      report_and_stop();
   end
endmodule : tb_video_buffer_channel_config_slave
